// ===== core/dqsc_map.vh
`ifndef DQSC_MAP_VH
`define DQSC_MAP_VH
// register byte offsets
`define DQSC_OFF_TX_COMP 12'h000
`define DQSC_OFF_RX_W0 12'h004
`define DQSC_OFF_RX_W1 12'h008
`define DQSC_OFF_RX_W2 12'h00C
`define DQSC_OFF_IRQ_STAT 12'h010
`define DQSC_OFF_IRQ_MASK 12'h014
// field positions
`define DQSC_PTR_HI 31
`define DQSC_PTR_LO 2
`define DQSC_MODE_BIT 0
`define DQSC_INPKT_BIT 0
`define DQSC_SKIP_HI 7
// interrupt status bit positions and status field width
`define DQSC_IRQ_TXQ 0
`define DQSC_IRQ_SOP 1
`define DQSC_IRQ_EOP 2
`define DQSC_IRQ_W 3
// reset values
`define DQSC_RST_PTR 30'h00000000
`define DQSC_RST_SKIP 8'h00
`define DQSC_RST_IRQ 3'h0
`endif

// ===== core/dqsc_irq.v
`include "dqsc_map.vh"
module dqsc_irq (
    input wire pclk,
    input wire presetn,
    input wire [`DQSC_IRQ_W-1:0] set_evt,
    input wire [`DQSC_IRQ_W-1:0] clr_w1c,
    input wire [`DQSC_IRQ_W-1:0] mask_in,
    output reg [`DQSC_IRQ_W-1:0] stat_r,
    output reg irq_r
);
    reg [`DQSC_IRQ_W-1:0] stat_nxt;

    // set beats clear so no event is lost
    always @* begin
        stat_nxt = (stat_r & ~clr_w1c) | set_evt;
    end

    // sticky status and masked level output
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= `DQSC_RST_IRQ;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            irq_r <= |(stat_nxt & mask_in);
        end
    end
endmodule

// ===== core/dqsc_top.v
// Function
// - pointer holds last finished end-of-packet descriptor
// - compare-mode write stores nothing, compares pointer
// - match drops queue interrupt, mismatch leaves it
// - writeback write loads pointer, raises queue interrupt
// - mode bit always reads back zero
// - receive skips offset bytes in first buffer
// - word one holds receive queue head pointer
// - word two holds packet first descriptor pointer
// - in-packet flag set mid-packet, else clear
//
// The APB interface to the registers and the register addresses were left to the implementer.
`include "dqsc_map.vh"
module dqsc_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // engine side: completion and receive progress
    input wire eng_eop_done,
    input wire [29:0] eng_eop_desc,
    input wire eng_head_load,
    input wire [29:0] eng_head_desc,
    input wire eng_pkt_start,
    input wire eng_pkt_end,
    input wire [29:0] eng_sop_desc,
    output reg [7:0] rx_skip_bytes,
    output reg [29:0] rx_head_ptr,
    output reg rx_in_packet,
    output reg txq_irq,
    output reg irq
);
    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    reg [29:0] last_eop_descriptor_pointer_r;
    reg [7:0] first_buffer_skip_bytes_r;
    reg [29:0] rx_queue_head_pointer_r;
    reg [29:0] packet_first_descriptor_pointer_r;
    reg in_packet_r;
    reg txq_int_r;
    reg [`DQSC_IRQ_W-1:0] irq_mask_r;
    reg txq_int_nxt;
    wire [`DQSC_IRQ_W-1:0] irq_stat;
    wire irq_lvl;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    function is_reg;
        input [11:0] a;
        input [11:0] off;
        begin
            is_reg = (a == off);
        end
    endfunction

    // access phase; zero wait states, so pready is high throughout
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire wr_tx = wr & is_reg(paddr, `DQSC_OFF_TX_COMP);
    wire wr_w0 = wr & is_reg(paddr, `DQSC_OFF_RX_W0);
    wire wr_w1 = wr & is_reg(paddr, `DQSC_OFF_RX_W1);
    wire wr_w2 = wr & is_reg(paddr, `DQSC_OFF_RX_W2);
    wire wr_st = wr & is_reg(paddr, `DQSC_OFF_IRQ_STAT);
    wire wr_mk = wr & is_reg(paddr, `DQSC_OFF_IRQ_MASK);
    wire mapped = is_reg(paddr, `DQSC_OFF_TX_COMP) | is_reg(paddr, `DQSC_OFF_RX_W0) |
                  is_reg(paddr, `DQSC_OFF_RX_W1) | is_reg(paddr, `DQSC_OFF_RX_W2) |
                  is_reg(paddr, `DQSC_OFF_IRQ_STAT) | is_reg(paddr, `DQSC_OFF_IRQ_MASK);
    wire wr_mode = pwdata[`DQSC_MODE_BIT];
    wire [29:0] wr_ptr = pwdata[`DQSC_PTR_HI:`DQSC_PTR_LO];
    // compare and writeback actions for the completion pointer
    wire cmp_hit = wr_tx & ~wr_mode & (wr_ptr == last_eop_descriptor_pointer_r);
    wire wbk = wr_tx & wr_mode;

    // ------------------------------------------------------------
    // queue interrupt
    // ------------------------------------------------------------
    // engine completion raises it as writeback does; a raise in the same
    // cycle as a matching compare wins, so a fresh completion is not lost
    always @* begin
        txq_int_nxt = txq_int_r;
        if (cmp_hit) begin
            txq_int_nxt = 1'b0;
        end
        if (wbk | eng_eop_done) begin
            txq_int_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // register updates
    // ------------------------------------------------------------
    // engine updates take priority over software writes in one cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_eop_descriptor_pointer_r <= `DQSC_RST_PTR;
            first_buffer_skip_bytes_r <= `DQSC_RST_SKIP;
            rx_queue_head_pointer_r <= `DQSC_RST_PTR;
            packet_first_descriptor_pointer_r <= `DQSC_RST_PTR;
            in_packet_r <= 1'b0;
            txq_int_r <= 1'b0;
            irq_mask_r <= `DQSC_RST_IRQ;
        end else begin
            txq_int_r <= txq_int_nxt;
            if (eng_eop_done) begin
                last_eop_descriptor_pointer_r <= eng_eop_desc;
            end else if (wbk) begin
                last_eop_descriptor_pointer_r <= wr_ptr;
            end
            if (wr_w0) begin
                first_buffer_skip_bytes_r <= pwdata[`DQSC_SKIP_HI:0];
            end
            if (eng_head_load) begin
                rx_queue_head_pointer_r <= eng_head_desc;
            end else if (wr_w1) begin
                rx_queue_head_pointer_r <= wr_ptr;
            end
            if (eng_pkt_start) begin
                packet_first_descriptor_pointer_r <= eng_sop_desc;
                in_packet_r <= 1'b1;
            end else if (eng_pkt_end) begin
                in_packet_r <= 1'b0;
            end else if (wr_w2) begin
                packet_first_descriptor_pointer_r <= wr_ptr;
                in_packet_r <= pwdata[`DQSC_INPKT_BIT];
            end
            if (wr_mk) begin
                irq_mask_r <= pwdata[`DQSC_IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // sticky event status
    // ------------------------------------------------------------
    dqsc_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt({eng_pkt_end, eng_pkt_start, eng_eop_done}),
        .clr_w1c(wr_st ? pwdata[`DQSC_IRQ_W-1:0] : 3'h0),
        .mask_in(irq_mask_r),
        .stat_r(irq_stat),
        .irq_r(irq_lvl)
    );

    // ------------------------------------------------------------
    // read mux, registered in the setup cycle
    // ------------------------------------------------------------
    // mode and reserved bits are forced to zero on read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b1;
        end else begin
            pready <= 1'b1;
            pslverr <= psel & ~penable & ~mapped;
            if (rd_setup) begin
                case (1'b1)
                    is_reg(paddr, `DQSC_OFF_TX_COMP):
                        prdata <= {last_eop_descriptor_pointer_r, 2'b00};
                    is_reg(paddr, `DQSC_OFF_RX_W0):
                        prdata <= {24'h000000, first_buffer_skip_bytes_r};
                    is_reg(paddr, `DQSC_OFF_RX_W1):
                        prdata <= {rx_queue_head_pointer_r, 2'b00};
                    is_reg(paddr, `DQSC_OFF_RX_W2):
                        prdata <= {packet_first_descriptor_pointer_r, 1'b0, in_packet_r};
                    is_reg(paddr, `DQSC_OFF_IRQ_STAT):
                        prdata <= {29'h00000000, irq_stat};
                    is_reg(paddr, `DQSC_OFF_IRQ_MASK):
                        prdata <= {29'h00000000, irq_mask_r};
                    default:
                        prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs to engine and interrupt controller
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_skip_bytes <= `DQSC_RST_SKIP;
            rx_head_ptr <= `DQSC_RST_PTR;
            rx_in_packet <= 1'b0;
            txq_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            rx_skip_bytes <= first_buffer_skip_bytes_r;
            rx_head_ptr <= rx_queue_head_pointer_r;
            rx_in_packet <= in_packet_r;
            txq_irq <= txq_int_nxt;
            irq <= irq_lvl;
        end
    end
endmodule

// ===== dv/dqsc_chk.sv
module dqsc_chk (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pslverr,
    input logic eng_eop_done,
    input logic eng_head_load,
    input logic [29:0] eng_head_desc,
    input logic eng_pkt_start,
    input logic [7:0] rx_skip_bytes,
    input logic [29:0] rx_head_ptr,
    input logic rx_in_packet,
    input logic txq_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access-phase and completion-pointer write decode
    logic acc;
    logic tcw;
    assign acc = psel & penable;
    assign tcw = acc & pwrite & (paddr == 12'h000);
    a_wb_raise: assert property (tcw && pwdata[0] |=> txq_irq)
        else $error("writeback did not raise queue irq");
    a_eop_raise: assert property (eng_eop_done |=> txq_irq)
        else $error("eop completion did not raise queue irq");
    a_cmp_no_raise: assert property (tcw && !pwdata[0] && !eng_eop_done && !txq_irq |=> !txq_irq)
        else $error("compare write raised queue irq");
    a_mode_rd_zero: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[1:0] == 2'h0)
        else $error("mode bit read back nonzero");
    // engine-side outputs trail the state register by one more flop
    a_skip_load: assert property (acc && pwrite && paddr == 12'h004
        |-> ##2 rx_skip_bytes == $past(pwdata[7:0], 2))
        else $error("skip count not loaded");
    a_head_load: assert property (eng_head_load
        |-> ##2 rx_head_ptr == $past(eng_head_desc, 2))
        else $error("head pointer not loaded");
    a_pkt_start: assert property (eng_pkt_start |-> ##2 rx_in_packet)
        else $error("in-packet not set");
    a_unmapped_err: assert property (acc && paddr > 12'h014 |-> pslverr)
        else $error("unmapped access without error");
    cover property (tcw && pwdata[0]);
    cover property (eng_pkt_start);
    cover property (acc && pslverr);
endmodule

bind dqsc_top dqsc_chk chk_i (.*);

// ===== dv/dqsc_eng.sv
// engine stand-in: one-cycle strobes, descriptor scrambled once released
module dqsc_eng (
    input wire pclk,
    output logic [3:0] stb,
    output logic [29:0] desc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        stb = 4'h0;
        desc = 30'h0;
    end
    task fire(input int k, input logic [29:0] d);
        @(posedge pclk);
        stb <= 4'h1 << k;
        desc <= d;
        @(posedge pclk);
        stb <= 4'h0;
        desc <= ~d;
    endtask
endmodule

// ===== dv/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, txq_irq, irq, rx_in_packet, err_q;
    logic [7:0] rx_skip_bytes;
    logic [29:0] rx_head_ptr, desc;
    logic [3:0] stb;
    int error_cnt = 0, tests_run = 0;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic t;} dqsc_row_t;
    dqsc_row_t rows[6] = '{
        '{12'h004, 32'hFFFFFFFF, 32'h000000FF, 1'b0},
        '{12'h008, 32'hFFFFFFFF, 32'hFFFFFFFC, 1'b0},
        '{12'h00C, 32'hFFFFFFFE, 32'hFFFFFFFC, 1'b0},
        '{12'h000, 32'h12345679, 32'h12345678, 1'b1},
        '{12'h000, 32'h00000000, 32'h12345678, 1'b1},
        '{12'h000, 32'h12345678, 32'h12345678, 1'b0}};
    always #20 pclk = ~pclk;
    dqsc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .eng_eop_done(stb[0]), .eng_eop_desc(desc),
        .eng_head_load(stb[1]), .eng_head_desc(desc), .eng_pkt_start(stb[2]),
        .eng_pkt_end(stb[3]), .eng_sop_desc(desc), .rx_skip_bytes(rx_skip_bytes),
        .rx_head_ptr(rx_head_ptr), .rx_in_packet(rx_in_packet), .txq_irq(txq_irq), .irq(irq));
    dqsc_eng eng (.pclk(pclk), .stb(stb), .desc(desc));
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
            error_cnt++;
        end
    endtask
    // apb master: holds the request until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            report_and_stop;
        end
        r = prdata;
        err_q = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].d, q);
            apb(0, rows[i].a, 0, q);
            chk(q, rows[i].r);
            chk(err_q, 0);
            chk(txq_irq, rows[i].t);
            $display("row %0d done", i);
        end
        chk(rx_skip_bytes, 8'hFF);
        apb(0, 12'h040, 0, q);
        chk(q, 0);
        chk(err_q, 1);
        eng.fire(0, 30'h0ABCDEF1);
        apb(0, 12'h000, 0, q);
        chk(q, {30'h0ABCDEF1, 2'b00});
        chk(txq_irq, 1);
        eng.fire(1, 30'h15555555);
        apb(0, 12'h008, 0, q);
        chk(q, {30'h15555555, 2'b00});
        eng.fire(2, 30'h2AAAAAAA);
        apb(0, 12'h00C, 0, q);
        chk(q, {30'h2AAAAAAA, 2'b01});
        eng.fire(3, 30'h0);
        apb(0, 12'h00C, 0, q);
        chk(q, {30'h2AAAAAAA, 2'b00});
        $display("engine test done");
        // all three events latched, masked so no irq yet
        apb(0, 12'h010, 0, q);
        chk(q, 32'h7);
        chk(irq, 0);
        apb(1, 12'h014, 32'h7, q);
        repeat (3) @(posedge pclk);
        chk(irq, 1);
        apb(1, 12'h010, 32'h7, q);
        repeat (3) @(posedge pclk);
        chk(irq, 0);
        $display("interrupt test done");
        presetn <= 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        for (int k = 0; k < 6; k++) begin
            apb(0, 12'(k * 4), 0, q);
            chk(q, 0);
        end
        chk(txq_irq, 0);
        $display("reset test done");
        report_and_stop;
    end
endmodule
